// >>> ccr_calendar_clock_registers.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_calendar_clock_registers #(
   parameter int SECOND_CYCLES = ccr_pkg::SECOND_CYCLES
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel
   input wire logic [ccr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // Write data channel
   input wire logic [ccr_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read address channel
   input wire logic [ccr_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // Read data channel
   output logic [ccr_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Trim values toward the oscillator
   output logic [6:0] analog_rate_trim,
   output logic [16:0] fine_rate_trim,
   output logic [1:0] fraction_rate_trim,
   // Timebase and calendar view
   output logic second_tick,
   output ccr_pkg::ccr_cal_type calendar
);

   ////////////////////////////////////////////////////////////////////////////////
   // State
   ccr_pkg::ccr_state_type q; // Registered state
   ccr_pkg::ccr_state_type next_q; // Next state
   logic tick; // Last cycle of the second
   logic [ccr_pkg::IDX_W-1:0] ar_idx; // Read word index
   logic wr_go; // Write executes this cycle
   localparam int SUB_W = ccr_pkg::SUBSEC_W; // Sub-second count width

   ////////////////////////////////////////////////////////////////////////////////
   // Days in a month, leap February when year is a multiple of four
   function automatic logic [4:0] month_days(input logic [3:0] mo, input logic [7:0] yr);
      logic [4:0] d;
      d = 5'h1f;
      case (mo)
         4'h2:
         begin
            d = (yr[1:0] == 2'h0) ? 5'h1d : 5'h1c;
         end
         4'h4, 4'h6, 4'h9, 4'hb:
         begin
            d = 5'h1e;
         end
         default:
         begin
            d = 5'h1f;
         end
      endcase
      return d;
   endfunction : month_days

   ////////////////////////////////////////////////////////////////////////////////
   // Advance the calendar by one second with carries
   function automatic ccr_pkg::ccr_cal_type advance(input ccr_pkg::ccr_cal_type c);
      ccr_pkg::ccr_cal_type r;
      r = c;
      if (c.seconds < ccr_pkg::SEC_MAX)
      begin
         r.seconds = c.seconds + 6'h01;
      end
      else
      begin
         r.seconds = 6'h00;
         if (c.minutes < ccr_pkg::SEC_MAX)
         begin
            r.minutes = c.minutes + 6'h01;
         end
         else
         begin
            r.minutes = 6'h00;
            if (c.hours < ccr_pkg::HOUR_MAX)
            begin
               r.hours = c.hours + 5'h01;
            end
            else
            begin
               r.hours = 5'h00;
               r.weekday = (c.weekday < ccr_pkg::WEEKDAY_MAX) ?
                  c.weekday + 3'h1 : ccr_pkg::WEEKDAY_MIN;
               if (c.date < month_days(c.month, c.year))
               begin
                  r.date = c.date + 5'h01;
               end
               else
               begin
                  r.date = ccr_pkg::DATE_MIN;
                  if (c.month < ccr_pkg::MONTH_MAX)
                  begin
                     r.month = c.month + 4'h1;
                  end
                  else
                  begin
                     r.month = 4'h1;
                     r.year = (c.year < ccr_pkg::YEAR_MAX) ? c.year + 8'h01 : 8'h00;
                  end
               end
            end
         end
      end
      return r;
   endfunction : advance

   ////////////////////////////////////////////////////////////////////////////////
   // Byte-lane merge of a write into an old value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
      logic [31:0] m;
      m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
      return (old & ~m) | (wd & m);
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////////
   // Read multiplexer, unused bits read zero
   function automatic logic [32:0] read_word(input ccr_pkg::ccr_state_type s,
                                             input logic [ccr_pkg::IDX_W-1:0] idx);
      logic [31:0] d;
      logic ok;
      d = 32'h0;
      ok = 1'b1;
      case (idx)
         ccr_pkg::IDX_SUBSEC_RESTART: d = {31'h0, s.ctl.restart_bit};
         ccr_pkg::IDX_ANALOG_TRIM: d = {25'h0, s.ctl.analog_trim};
         ccr_pkg::IDX_SECONDS: d = {26'h0, s.cal.seconds};
         ccr_pkg::IDX_MINUTES: d = {26'h0, s.cal.minutes};
         ccr_pkg::IDX_HOURS: d = {27'h0, s.cal.hours};
         ccr_pkg::IDX_WEEKDAY: d = {29'h0, s.cal.weekday};
         ccr_pkg::IDX_DATE: d = {27'h0, s.cal.date};
         ccr_pkg::IDX_MONTH: d = {28'h0, s.cal.month};
         ccr_pkg::IDX_YEAR: d = {24'h0, s.cal.year};
         ccr_pkg::IDX_FINE_TRIM: d = {15'h0, s.ctl.fine_trim};
         ccr_pkg::IDX_FRACTION_TRIM: d = {30'h0, s.ctl.fraction_trim};
         ccr_pkg::IDX_WRITE_UNLOCK: d = 32'h0;
         ccr_pkg::IDX_COMBINED_TRIM: d = {13'h0, s.ctl.fine_trim, s.ctl.fraction_trim};
         default: ok = 1'b0;
      endcase
      return {ok, d};
   endfunction : read_word

   ////////////////////////////////////////////////////////////////////////////////
   // Combinational decode helpers
   assign tick = (q.ctl.subsec == SUB_W'(SECOND_CYCLES - 1));
   assign ar_idx = s_axi_araddr[ccr_pkg::ADDR_W-1:2];
   // Both halves present and no response outstanding
   assign wr_go = q.ctl.aw_held && q.ctl.w_held && !q.ctl.bvalid;

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      logic [31:0] mw;
      logic [32:0] rd;
      logic is_time;
      logic ok;
      mw = 32'h0;
      rd = 33'h0;
      is_time = 1'b0;
      ok = 1'b1;
      next_q = q;
      next_q.ctl.tick = tick;
      // Free-running sub-second count
      next_q.ctl.subsec = tick ? '0 : q.ctl.subsec + SUB_W'(1);
      // apply held writes on the tick
      if (tick)
      begin
         next_q.cal = advance(q.cal);
         if (q.ctl.pend.seconds) next_q.cal.seconds = q.shadow.seconds;
         if (q.ctl.pend.minutes) next_q.cal.minutes = q.shadow.minutes;
         if (q.ctl.pend.hours) next_q.cal.hours = q.shadow.hours;
         if (q.ctl.pend.weekday) next_q.cal.weekday = q.shadow.weekday;
         if (q.ctl.pend.date) next_q.cal.date = q.shadow.date;
         if (q.ctl.pend.month) next_q.cal.month = q.shadow.month;
         if (q.ctl.pend.year) next_q.cal.year = q.shadow.year;
         next_q.ctl.pend = '0;
      end
      // Address and data are caught independently
      if (s_axi_awvalid && !q.ctl.aw_held)
      begin
         next_q.ctl.aw_held = 1'b1;
         next_q.ctl.aw_idx = s_axi_awaddr[ccr_pkg::ADDR_W-1:2];
      end
      if (s_axi_wvalid && !q.ctl.w_held)
      begin
         next_q.ctl.w_held = 1'b1;
         next_q.ctl.wdata = s_axi_wdata;
         next_q.ctl.wstrb = s_axi_wstrb;
      end
      // Response retires on its handshake
      if (q.ctl.bvalid && s_axi_bready)
      begin
         next_q.ctl.bvalid = 1'b0;
      end
      // Register write
      if (wr_go)
      begin
         next_q.ctl.aw_held = 1'b0;
         next_q.ctl.w_held = 1'b0;
         next_q.ctl.bvalid = 1'b1;
         rd = read_word(q, q.ctl.aw_idx);
         ok = rd[32];
         mw = merge(rd[31:0], q.ctl.wdata, q.ctl.wstrb);
         // unlock lasts for one write only
         next_q.ctl.unlock = (q.ctl.aw_idx == ccr_pkg::IDX_WRITE_UNLOCK);
         is_time = q.ctl.unlock;
         case (q.ctl.aw_idx)
            ccr_pkg::IDX_SUBSEC_RESTART:
            begin
               next_q.ctl.restart_bit = mw[0];
               if (mw[0]) next_q.ctl.subsec = '0;
            end
            ccr_pkg::IDX_ANALOG_TRIM: next_q.ctl.analog_trim = mw[6:0];
            ccr_pkg::IDX_SECONDS:
            begin
               next_q.shadow.seconds = is_time ? mw[5:0] : q.shadow.seconds;
               next_q.ctl.pend.seconds = is_time | next_q.ctl.pend.seconds;
            end
            ccr_pkg::IDX_MINUTES:
            begin
               next_q.shadow.minutes = is_time ? mw[5:0] : q.shadow.minutes;
               next_q.ctl.pend.minutes = is_time | next_q.ctl.pend.minutes;
            end
            ccr_pkg::IDX_HOURS:
            begin
               next_q.shadow.hours = is_time ? mw[4:0] : q.shadow.hours;
               next_q.ctl.pend.hours = is_time | next_q.ctl.pend.hours;
            end
            ccr_pkg::IDX_WEEKDAY:
            begin
               next_q.shadow.weekday = is_time ? mw[2:0] : q.shadow.weekday;
               next_q.ctl.pend.weekday = is_time | next_q.ctl.pend.weekday;
            end
            ccr_pkg::IDX_DATE:
            begin
               next_q.shadow.date = is_time ? mw[4:0] : q.shadow.date;
               next_q.ctl.pend.date = is_time | next_q.ctl.pend.date;
            end
            ccr_pkg::IDX_MONTH:
            begin
               next_q.shadow.month = is_time ? mw[3:0] : q.shadow.month;
               next_q.ctl.pend.month = is_time | next_q.ctl.pend.month;
            end
            ccr_pkg::IDX_YEAR:
            begin
               next_q.shadow.year = is_time ? mw[7:0] : q.shadow.year;
               next_q.ctl.pend.year = is_time | next_q.ctl.pend.year;
            end
            ccr_pkg::IDX_FINE_TRIM: next_q.ctl.fine_trim = mw[16:0];
            ccr_pkg::IDX_FRACTION_TRIM: next_q.ctl.fraction_trim = mw[1:0];
            ccr_pkg::IDX_COMBINED_TRIM:
            begin
               next_q.ctl.fine_trim = mw[ccr_pkg::COMBINED_FINE_LSB +: 17];
               next_q.ctl.fraction_trim = mw[ccr_pkg::COMBINED_FRAC_LSB +: 2];
            end
            default:
            begin
               // Unlock or unmapped: nothing stored
            end
         endcase
         next_q.ctl.bresp = ok ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
      end
      // Read data retires on its handshake
      if (q.ctl.rvalid && s_axi_rready)
      begin
         next_q.ctl.rvalid = 1'b0;
      end
      // One read at a time, answered next cycle
      if (s_axi_arvalid && !q.ctl.rvalid)
      begin
         rd = read_word(q, ar_idx);
         next_q.ctl.rvalid = 1'b1;
         next_q.ctl.rdata = rd[31:0];
         next_q.ctl.rresp = rd[32] ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register; calendar and shadow are never reset
   always_ff @(posedge aclk)
   begin
      q <= next_q;
      if (!aresetn)
      begin
         q.ctl <= '0;
         q.ctl.analog_trim <= ccr_pkg::ANALOG_TRIM_RESET;
         q.ctl.fine_trim <= ccr_pkg::FINE_TRIM_RESET;
         q.ctl.fraction_trim <= ccr_pkg::FRACTION_TRIM_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign s_axi_awready = !q.ctl.aw_held;
   assign s_axi_wready = !q.ctl.w_held;
   assign s_axi_bvalid = q.ctl.bvalid;
   assign s_axi_bresp = q.ctl.bresp;
   assign s_axi_arready = !q.ctl.rvalid;
   assign s_axi_rvalid = q.ctl.rvalid;
   assign s_axi_rdata = q.ctl.rdata;
   assign s_axi_rresp = q.ctl.rresp;
   assign analog_rate_trim = q.ctl.analog_trim;
   assign fine_rate_trim = q.ctl.fine_trim;
   assign fraction_rate_trim = q.ctl.fraction_trim;
   assign second_tick = q.ctl.tick;
   assign calendar = q.cal;

endmodule : ccr_calendar_clock_registers
`default_nettype wire

// >>> ccr_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_chk #(
   parameter int SECOND_CYCLES = 50
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic s_axi_arvalid,
   input wire logic [ccr_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Trims, tick and calendar
   input wire logic [6:0] analog_rate_trim,
   input wire logic [16:0] fine_rate_trim,
   input wire logic [1:0] fraction_rate_trim,
   input wire logic second_tick,
   input wire ccr_pkg::ccr_cal_type calendar
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////
   // Cycles since the last tick, saturating at one second
   int unsigned since_tick;

   // Restart only lengthens a second, so a lower bound is safe
   always_ff @(posedge aclk)
   begin
      if (!aresetn || second_tick)
         since_tick <= 0;
      else if (since_tick < SECOND_CYCLES)
         since_tick <= since_tick + 1;
   end

   ////////////////////////////////////////////////////////////
   b_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   r_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   b_latency_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not two cycles after transfer");
   r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after address");
   err_zero_a: assert property (
      s_axi_rvalid && s_axi_rresp == ccr_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("error read carries data");
   trim_reset_a: assert property (disable iff (1'b0)
      !aresetn |=> analog_rate_trim == 7'h40 && fine_rate_trim == 17'h00004
      && fraction_rate_trim == 2'h0)
      else $error("trim reset values wrong");
   trim_write_a: assert property (
      $past(aresetn) && !$stable({analog_rate_trim, fine_rate_trim, fraction_rate_trim})
      |-> $rose(s_axi_bvalid))
      else $error("trim changed without a write");
   tick_pulse_a: assert property (second_tick |=> !second_tick)
      else $error("tick longer than one cycle");
   tick_period_a: assert property (
      second_tick |-> since_tick >= SECOND_CYCLES - 1)
      else $error("second shorter than its count");
   cal_update_a: assert property ($changed(calendar) |-> ##[0:1] second_tick)
      else $error("calendar changed away from a second boundary");
   cal_keep_a: assert property (disable iff (1'b0)
      $changed(calendar) |-> $past(aresetn))
      else $error("calendar changed under reset");
endmodule : ccr_chk

bind ccr_calendar_clock_registers ccr_chk #(.SECOND_CYCLES(SECOND_CYCLES)) ccr_chk_i (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_arvalid,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .analog_rate_trim,
   .fine_rate_trim, .fraction_rate_trim, .second_tick, .calendar);
`default_nettype wire

// >>> ccr_pkg.sv
`default_nettype none
package ccr_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int ADDR_W = 16; // Byte address width
   localparam int IDX_W = 14; // Word index width
   localparam int DATA_W = 32; // Bus data width

   ////////////////////////////////////////////////////////////////////////////////
   // Register indexes, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_SUBSEC_RESTART = 14'h2010;
   localparam logic [IDX_W-1:0] IDX_ANALOG_TRIM = 14'h2011;
   localparam logic [IDX_W-1:0] IDX_SECONDS = 14'h2015;
   localparam logic [IDX_W-1:0] IDX_MINUTES = 14'h2016;
   localparam logic [IDX_W-1:0] IDX_HOURS = 14'h2017;
   localparam logic [IDX_W-1:0] IDX_WEEKDAY = 14'h2018;
   localparam logic [IDX_W-1:0] IDX_DATE = 14'h2019;
   localparam logic [IDX_W-1:0] IDX_MONTH = 14'h201a;
   localparam logic [IDX_W-1:0] IDX_YEAR = 14'h201b;
   localparam logic [IDX_W-1:0] IDX_FINE_TRIM = 14'h201c;
   localparam logic [IDX_W-1:0] IDX_FRACTION_TRIM = 14'h201e;
   localparam logic [IDX_W-1:0] IDX_WRITE_UNLOCK = 14'h201f;
   localparam logic [IDX_W-1:0] IDX_COMBINED_TRIM = 14'h2020;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values and field positions
   localparam logic [6:0] ANALOG_TRIM_RESET = 7'h40;
   localparam logic [16:0] FINE_TRIM_RESET = 17'h00004;
   localparam logic [1:0] FRACTION_TRIM_RESET = 2'h0;
   localparam int COMBINED_FRAC_LSB = 0; // Fraction in combined word
   localparam int COMBINED_FINE_LSB = 2; // Fine trim above it

   ////////////////////////////////////////////////////////////////////////////////
   // Calendar limits
   localparam logic [5:0] SEC_MAX = 6'h3b; // 59
   localparam logic [4:0] HOUR_MAX = 5'h17; // 23
   localparam logic [2:0] WEEKDAY_MIN = 3'h1; // Sunday
   localparam logic [2:0] WEEKDAY_MAX = 3'h7;
   localparam logic [4:0] DATE_MIN = 5'h01;
   localparam logic [3:0] MONTH_MAX = 4'hc; // 12
   localparam logic [7:0] YEAR_MAX = 8'h63; // 99

   ////////////////////////////////////////////////////////////////////////////////
   // Timing: one second at a 25 ns clock
   localparam longint SECOND_NS = 1000000000;
   localparam longint CLK_PERIOD_NS = 25;
   localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
   localparam int SUBSEC_W = 26; // Holds SECOND_CYCLES

   ////////////////////////////////////////////////////////////////////////////////
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Calendar fields
   typedef struct packed {
      logic [7:0] year;
      logic [3:0] month;
      logic [4:0] date;
      logic [2:0] weekday;
      logic [4:0] hours;
      logic [5:0] minutes;
      logic [5:0] seconds;
   } ccr_cal_type;

   // One pending flag per calendar field
   typedef struct packed {
      logic year;
      logic month;
      logic date;
      logic weekday;
      logic hours;
      logic minutes;
      logic seconds;
   } ccr_pend_type;

   // Control state, reset by aresetn
   typedef struct packed {
      logic [SUBSEC_W-1:0] subsec;
      logic restart_bit;
      logic [6:0] analog_trim;
      logic [16:0] fine_trim;
      logic [1:0] fraction_trim;
      logic unlock;
      ccr_pend_type pend;
      logic aw_held;
      logic [IDX_W-1:0] aw_idx;
      logic w_held;
      logic [DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [DATA_W-1:0] rdata;
      logic tick;
   } ccr_ctl_type;

   // Whole module state
   typedef struct packed {
      ccr_cal_type cal; // Kept across reset
      ccr_cal_type shadow; // Values waiting for the next second
      ccr_ctl_type ctl;
   } ccr_state_type;

endpackage : ccr_pkg
`default_nettype wire

// >>> test_ccr_calendar_clock_registers.sv
`timescale 1ns/1ps
`default_nettype none
module test_ccr_calendar_clock_registers;
   localparam int SEC_CYC = 200; // Short second keeps the run brief
   localparam logic [1:0] OK = ccr_pkg::RESP_OKAY;
   // Bus drive
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [15:0] s_axi_awaddr = 16'h0000;
   logic s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf; // Whole words only
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic [15:0] s_axi_araddr = 16'h0000;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   // Design outputs
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, second_tick;
   logic [1:0] s_axi_bresp, s_axi_rresp, fraction_rate_trim;
   logic [31:0] s_axi_rdata;
   logic [6:0] analog_rate_trim;
   logic [16:0] fine_rate_trim;
   ccr_pkg::ccr_cal_type calendar, exp_cal;
   // Tallies and loop state
   int n_mismatch = 0;
   int compares = 0;
   int i, n;
   // Start times and the time one second later
   ccr_pkg::ccr_cal_type from_v [5] = '{{8'h00, 4'h2, 5'h1c, 3'h7, 5'h17, 6'h3b, 6'h3b},
      {8'h05, 4'h2, 5'h1c, 3'h3, 5'h17, 6'h3b, 6'h3b}, {8'h63, 4'hc, 5'h1f, 3'h1, 5'h17, 6'h3b,
      6'h3b}, {8'h04, 4'h2, 5'h1d, 3'h5, 5'h17, 6'h3b, 6'h3b}, {8'h10, 4'h4, 5'h1e, 3'h2, 5'h17,
      6'h3b, 6'h3b}};
   ccr_pkg::ccr_cal_type to_v [5] = '{{8'h00, 4'h2, 5'h1d, 3'h1, 17'h0},
      {8'h05, 4'h3, 5'h01, 3'h4, 17'h0}, {8'h00, 4'h1, 5'h01, 3'h2, 17'h0},
      {8'h04, 4'h3, 5'h01, 3'h6, 17'h0}, {8'h10, 4'h5, 5'h01, 3'h3, 17'h0}};

   ccr_calendar_clock_registers #(.SECOND_CYCLES(SEC_CYC)) ccr_calendar_clock_registers_i (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .analog_rate_trim, .fine_rate_trim, .fraction_rate_trim, .second_tick,
      .calendar);

   // Free running 40 MHz clock
   always
      #12.5 aclk = ~aclk;

   ////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
   begin
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   end
   endtask : check

   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [13:0] idx, input logic [31:0] d, input logic [1:0] er);
      logic done;
   begin
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      done = 1'b0;
      for (int t = 0; t < 40 && !done; t++)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         done = s_axi_bvalid && s_axi_bready;
         // Late ready makes the response wait one cycle
         if (!done && t > 1)
            s_axi_bready <= 1'b1;
      end
      check({37'h0, done, s_axi_bresp}, {37'h0, 1'b1, er}, "write response");
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   end
   endtask : wr

   // Read one word and compare data and response
   task automatic rd(input logic [13:0] idx, input logic [31:0] ed, input logic [1:0] er);
      logic done;
   begin
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      done = 1'b0;
      for (int t = 0; t < 40 && !done; t++)
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         done = s_axi_rvalid && s_axi_rready;
         // Late ready makes the read data wait one cycle
         if (!done && t > 0)
            s_axi_rready <= 1'b1;
      end
      check({5'h0, done, s_axi_rresp, s_axi_rdata}, {5'h0, 1'b1, er, ed}, "read");
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   end
   endtask : rd

   // Unlocked time-field write
   task automatic tw(input logic [13:0] idx, input logic [31:0] d);
   begin
      wr(ccr_pkg::IDX_WRITE_UNLOCK, 32'h0, OK);
      wr(idx, d, OK);
   end
   endtask : tw

   // Restart the second first, so all fields land on one boundary
   task automatic set_cal(input ccr_pkg::ccr_cal_type c);
   begin
      wr(ccr_pkg::IDX_SUBSEC_RESTART, 32'h1, OK);
      tw(ccr_pkg::IDX_SECONDS, 32'(c.seconds));
      tw(ccr_pkg::IDX_MINUTES, 32'(c.minutes));
      tw(ccr_pkg::IDX_HOURS, 32'(c.hours));
      tw(ccr_pkg::IDX_WEEKDAY, 32'(c.weekday));
      tw(ccr_pkg::IDX_DATE, 32'(c.date));
      tw(ccr_pkg::IDX_MONTH, 32'(c.month));
      tw(ccr_pkg::IDX_YEAR, 32'(c.year));
   end
   endtask : set_cal

   // Wait for a tick; n gives the cycles waited
   task automatic wait_tick(output int n);
   begin
      for (n = 0; n < 2 * SEC_CYC && second_tick !== 1'b1; n++)
         @(posedge aclk);
      check({39'h0, second_tick}, 40'h1, "second tick");
      @(posedge aclk);
   end
   endtask : wait_tick

   // Counts, verdict and end of run
   task automatic conclude;
   begin
      $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask : conclude

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check({14'h0, analog_rate_trim, fine_rate_trim, fraction_rate_trim}, 40'h2000010, "trims");
      rd(ccr_pkg::IDX_ANALOG_TRIM, 32'h40, OK);
      rd(ccr_pkg::IDX_FINE_TRIM, 32'h4, OK);
      rd(ccr_pkg::IDX_FRACTION_TRIM, 32'h0, OK);
      rd(ccr_pkg::IDX_SUBSEC_RESTART, 32'h0, OK);
      wr(14'h201d, 32'h5, ccr_pkg::RESP_SLVERR);
      rd(14'h201d, 32'h0, ccr_pkg::RESP_SLVERR);
      $display("test reset and unmapped done");
      wr(ccr_pkg::IDX_COMBINED_TRIM, 32'h00040103, OK);
      rd(ccr_pkg::IDX_FINE_TRIM, 32'h10040, OK);
      rd(ccr_pkg::IDX_FRACTION_TRIM, 32'h3, OK);
      check({21'h0, fine_rate_trim, fraction_rate_trim}, 40'h40103, "trim ports");
      wr(ccr_pkg::IDX_ANALOG_TRIM, 32'hffffffff, OK);
      rd(ccr_pkg::IDX_ANALOG_TRIM, 32'h7f, OK);
      $display("test trims done");
      for (i = 0; i < 5; i++)
      begin
         set_cal(from_v[i]);
         wait_tick(n);
         check({3'h0, calendar}, {3'h0, from_v[i]}, "applied time");
         wait_tick(n);
         check({3'h0, calendar}, {3'h0, to_v[i]}, "rolled time");
      end
      $display("test calendar rollover done");
      exp_cal = to_v[4];
      wr(ccr_pkg::IDX_SECONDS, 32'h11, OK);
      wr(ccr_pkg::IDX_WRITE_UNLOCK, 32'h0, OK);
      wr(ccr_pkg::IDX_ANALOG_TRIM, 32'h15, OK);
      wr(ccr_pkg::IDX_SECONDS, 32'h22, OK);
      wait_tick(n);
      exp_cal.seconds = 6'h01;
      check({3'h0, calendar}, {3'h0, exp_cal}, "locked write");
      tw(ccr_pkg::IDX_MINUTES, 32'h1e);
      rd(ccr_pkg::IDX_MINUTES, 32'h0, OK);
      wait_tick(n);
      exp_cal.minutes = 6'h1e;
      exp_cal.seconds = 6'h02;
      check({3'h0, calendar}, {3'h0, exp_cal}, "delayed write");
      $display("test lock and delay done");
      // Mid-second restart must push the next tick a full second out
      repeat (SEC_CYC / 2) @(posedge aclk);
      wr(ccr_pkg::IDX_SUBSEC_RESTART, 32'h1, OK);
      wait_tick(n);
      check({39'h0, n >= SEC_CYC - 8 && n <= SEC_CYC + 2}, 40'h1, "restart delay");
      rd(ccr_pkg::IDX_SUBSEC_RESTART, 32'h1, OK);
      $display("test restart done");
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      exp_cal.seconds = 6'h03;
      check({3'h0, calendar}, {3'h0, exp_cal}, "kept time");
      rd(ccr_pkg::IDX_MINUTES, 32'h1e, OK);
      rd(ccr_pkg::IDX_ANALOG_TRIM, 32'h40, OK);
      $display("test reset keep done");
      conclude();
   end

   // Hang guard, well past the expected length
   initial
   begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      $display("wrong value at %0t: watchdog expired", $time);
      conclude();
   end
endmodule : test_ccr_calendar_clock_registers
`default_nettype wire
